//--- design/rco_pkg.sv
// Purpose: shared constants, carriers and types of the rtc clock-out block
// Assumes: 25 MHz reference clock, byte addressed Avalon-MM slave
// Notes: register data sits in bits 7:0, upper bits read zero
package rco_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned ADJ_TIME_NS = 122100;
  localparam int unsigned ADJ_MAX_CYC = ADJ_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned OSC_PER_SEC_DEF = 32768;
  localparam logic [1:0] TIMEOUT_HALVES = 2'h2;
  localparam logic [1:0] INIT_HALVES = 2'h2;
  localparam logic [1:0] BOOT_DONE = 2'h3;

  localparam logic [5:0] A_SEC = 6'h00;
  localparam logic [5:0] A_MIN = 6'h04;
  localparam logic [5:0] A_HOUR = 6'h08;
  localparam logic [5:0] A_DAY = 6'h0c;
  localparam logic [5:0] A_MON = 6'h10;
  localparam logic [5:0] A_YEAR = 6'h14;
  localparam logic [5:0] A_TRIM = 6'h18;
  localparam logic [5:0] A_AAM = 6'h1c;
  localparam logic [5:0] A_AAH = 6'h20;
  localparam logic [5:0] A_ABM = 6'h24;
  localparam logic [5:0] A_ABH = 6'h28;
  localparam logic [5:0] A_CTL1 = 6'h2c;
  localparam logic [5:0] A_CTL2 = 6'h30;
  localparam logic [5:0] A_SES = 6'h34;
  localparam logic [5:0] A_ADJ = 6'h38;

  localparam int C1_AAE = 7;
  localparam int C1_ABE = 6;
  localparam int C1_SEL = 4;
  localparam int C1_PSEL = 0;
  localparam int C2_HALT = 4;
  localparam int C2_CLKEN = 3;
  localparam int C2_PFLAG = 2;
  localparam int C2_AAF = 1;
  localparam int C2_ABF = 0;
  localparam int ADJ_BIT = 0;

  localparam logic [2:0] PS_OFF = 3'h0;
  localparam logic [2:0] PS_LOW = 3'h1;
  localparam logic [2:0] PS_2HZ = 3'h2;
  localparam logic [2:0] PS_1HZ = 3'h3;
  localparam logic [2:0] PS_SEC = 3'h4;
  localparam logic [2:0] PS_MIN = 3'h5;
  localparam logic [2:0] PS_HOUR = 3'h6;
  localparam logic [2:0] PS_MONTH = 3'h7;

  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic HALT_RST = 1'b1;
  localparam logic CLKEN_RST = 1'b0;
  localparam logic [7:0] RD_INIT = 8'hff;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] mon;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rco_time_s;

  localparam rco_time_s TIME_RST = '{year: 7'h00, mon: 4'h1, day: 5'h01,
                                     hour: 5'h00, min: 6'h00, sec: 6'h00};

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } rco_avs_req_s;

  typedef struct packed {
    logic irq_a_n;
    logic irq_b_n;
    logic single_n;
    logic slow_clk;
    logic slow_clk_oe_n;
  } rco_pins_s;

  typedef enum logic [0:0] {SES_IDLE, SES_OPEN} rco_ses_e;
endpackage : rco_pkg

//--- design/rco_osc_front.sv
// Purpose: bring the crystal clock into the reference domain
// Assumes: oscillator much slower than the reference clock
// Notes: level and rising-edge pulse both come after two flops
`timescale 1ns/1ps
`default_nettype none
module rco_osc_front (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_osc_clk,
  output logic o_osc_level,
  output logic o_osc_rise
);
  import rco_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } rco_front_s;

  rco_front_s st_ff;
  rco_front_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = i_osc_clk;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_osc_level = st_ff.sync;
  assign o_osc_rise = st_ff.sync & ~st_ff.prev;
endmodule : rco_osc_front
`default_nettype wire

//--- design/rco_rtc_top.sv
// Purpose: rtc counters, clock output, interrupt pins and access guards
// Assumes: Avalon-MM slave with waitrequest, oscillator sampled as a pin
// Notes: TWO_PINS selects the two-pin or the single-pin variant
// Contract
// - two-pin variant: clock-out enable bit one stops clock, pin B high
// - single-pin variant: enable bit one turns slow clock pin off
// - slow clock comes straight from oscillator, trim never touches it
// - after power-up halt flag set and slow clock output on
// - during initialization reads give all ones, host retries
// - halt flag zero if backup held supply, one after full power-up
// - any write to control register two clears halt flag
// - access still open 0.5 to 1.0 seconds after start is ended
// - adjust bit one rounds seconds by thirty within 122.1 us
// - writing zero to periodic flag releases periodic interrupt
// - alarm B or periodic event holds pin B low until flag cleared
// - several sources on one pin give active-low OR
// - periodic select: off, held low, 2 Hz, 1 Hz, four level modes
`timescale 1ns/1ps
`default_nettype none
module rco_rtc_top #(
  parameter int unsigned OSC_PER_SEC = rco_pkg::OSC_PER_SEC_DEF,
  parameter bit TWO_PINS = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_osc_clk,
  input wire logic i_backup_kept,
  input wire rco_pkg::rco_avs_req_s i_avs,
  output logic o_avs_waitrequest,
  output logic [31:0] o_avs_readdata,
  output var rco_pkg::rco_pins_s o_pins
);
  import rco_pkg::*;

  localparam int ADJ_WIN = (ADJ_MAX_CYC > 1000) ? 1000 : int'(ADJ_MAX_CYC);

  typedef struct packed {
    rco_time_s t;
    logic [7:0] trim;
    logic [5:0] aa_min;
    logic [4:0] aa_hour;
    logic [5:0] ab_min;
    logic [4:0] ab_hour;
    logic aae;
    logic abe;
    logic [1:0] sel;
    logic [2:0] psel;
    logic pflag;
    logic aaf;
    logic abf;
    logic clk_en;
    logic halt;
    logic [16:0] div;
    rco_ses_e ses;
    logic [1:0] ses_halves;
    logic pend;
    logic [1:0] init_left;
    logic [1:0] boot;
    logic strap_meta;
    logic strap;
    logic ack;
    logic [7:0] rdata;
    logic pin_a_n;
    logic pin_b_n;
    logic single_n;
    logic slow_clk;
    logic slow_oe_n;
  } rco_main_s;

  rco_main_s st_ff;
  rco_main_s nxt_st;
  logic osc_level;
  logic osc_rise;
  logic [16:0] lim;
  logic [16:0] half;
  logic [16:0] quarter;
  logic sec_tick;
  logic half_tick;
  logic init_busy;
  logic req;
  logic take;
  logic wr;
  logic tacc;
  logic adv;
  logic pevent;
  logic wave2;
  logic wave1;
  logic per_act;
  logic a_act;
  logic b_act;
  logic all_act;
  logic [5:0] addr;
  logic [7:0] wd;
  logic [7:0] rv;
  rco_time_s tn;

  function automatic logic [4:0] days_in(input logic [3:0] mon);
    unique case (mon)
      4'h2: days_in = 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: days_in = 5'h1e;
      default: days_in = 5'h1f;
    endcase
  endfunction : days_in

  function automatic rco_time_s time_inc(input rco_time_s t);
    rco_time_s r;
    r = t;
    r.sec = t.sec + 6'h01;
    if (t.sec >= 6'h3b) begin
      r.sec = 6'h00;
      r.min = t.min + 6'h01;
      if (t.min >= 6'h3b) begin
        r.min = 6'h00;
        r.hour = t.hour + 5'h01;
        if (t.hour >= 5'h17) begin
          r.hour = 5'h00;
          r.day = t.day + 5'h01;
          if (t.day >= days_in(t.mon)) begin
            r.day = 5'h01;
            r.mon = t.mon + 4'h1;
            if (t.mon >= 4'hc) begin
              r.mon = 4'h1;
              r.year = (t.year >= 7'h63) ? 7'h00 : t.year + 7'h01;
            end
          end
        end
      end
    end
    return r;
  endfunction : time_inc

  function automatic rco_time_s adj_round(input rco_time_s t);
    rco_time_s r;
    r = t;
    if (t.sec >= 6'h1e) begin
      r.sec = 6'h3b;
      r = time_inc(r);
    end else begin
      r.sec = 6'h00;
    end
    return r;
  endfunction : adj_round

  rco_osc_front u_front (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_osc_clk(i_osc_clk),
    .o_osc_level(osc_level),
    .o_osc_rise(osc_rise)
  );

  always_comb begin
    nxt_st = st_ff;
    tn = st_ff.t;
    rv = RD_UNMAPPED;
    pevent = 1'b0;
    adv = 1'b0;
    // second divider, trim shifts only the counting, never the clock pin
    lim = 17'(OSC_PER_SEC) + {{9{st_ff.trim[7]}}, st_ff.trim};
    half = lim >> 1;
    quarter = lim >> 2;
    sec_tick = osc_rise && (st_ff.div >= lim - 17'h1);
    half_tick = osc_rise && ((st_ff.div == half - 17'h1) || sec_tick);
    if (osc_rise) begin
      nxt_st.div = sec_tick ? 17'h0 : st_ff.div + 17'h1;
    end
    wave1 = st_ff.div < half;
    wave2 = (st_ff.div < quarter) || ((st_ff.div >= half) && (st_ff.div < half + quarter));
    // backup strap caught after reset release
    nxt_st.strap_meta = i_backup_kept;
    nxt_st.strap = st_ff.strap_meta;
    if (st_ff.boot != BOOT_DONE) begin
      nxt_st.boot = st_ff.boot + 2'h1;
    end
    if (st_ff.boot == BOOT_DONE - 2'h1 && st_ff.strap) begin
      nxt_st.halt = 1'b0;
    end
    init_busy = st_ff.init_left != 2'h0;
    if (init_busy && half_tick) begin
      nxt_st.init_left = st_ff.init_left - 2'h1;
    end
    // bus slave: one wait state, data latched as the wait state ends
    addr = {i_avs.address[5:2], 2'h0};
    wd = i_avs.writedata[7:0];
    req = i_avs.read || i_avs.write;
    nxt_st.ack = req && !st_ff.ack;
    take = req && st_ff.ack;
    wr = take && i_avs.write && !init_busy;
    tacc = take && !init_busy && (addr <= A_YEAR);
    unique case (addr)
      A_SEC: rv = {2'h0, st_ff.t.sec};
      A_MIN: rv = {2'h0, st_ff.t.min};
      A_HOUR: rv = {3'h0, st_ff.t.hour};
      A_DAY: rv = {3'h0, st_ff.t.day};
      A_MON: rv = {4'h0, st_ff.t.mon};
      A_YEAR: rv = {1'h0, st_ff.t.year};
      A_TRIM: rv = st_ff.trim;
      A_AAM: rv = {2'h0, st_ff.aa_min};
      A_AAH: rv = {3'h0, st_ff.aa_hour};
      A_ABM: rv = {2'h0, st_ff.ab_min};
      A_ABH: rv = {3'h0, st_ff.ab_hour};
      A_CTL1: rv = {st_ff.aae, st_ff.abe, st_ff.sel, 1'b0, st_ff.psel};
      A_CTL2: rv = {3'h0, st_ff.halt, st_ff.clk_en, st_ff.pflag, st_ff.aaf, st_ff.abf};
      A_SES: rv = {6'h00, init_busy, st_ff.ses == SES_OPEN};
      default: rv = RD_UNMAPPED;
    endcase
    if (req && !st_ff.ack) begin
      nxt_st.rdata = init_busy ? RD_INIT : rv;
    end
    // access guard: counters hold still while an access is open
    unique case (st_ff.ses)
      SES_IDLE: begin
        adv = sec_tick || st_ff.pend;
        if (tacc) begin
          nxt_st.ses = SES_OPEN;
          nxt_st.ses_halves = 2'h0;
        end
      end
      SES_OPEN: begin
        if (sec_tick) begin
          nxt_st.pend = 1'b1;
        end
        if (half_tick) begin
          nxt_st.ses_halves = st_ff.ses_halves + 2'h1;
        end
        if ((wr && addr == A_SES) ||
            (half_tick && st_ff.ses_halves == TIMEOUT_HALVES - 2'h1)) begin
          nxt_st.ses = SES_IDLE;
        end
      end
    endcase
    if (adv) begin
      tn = time_inc(st_ff.t);
      nxt_st.t = tn;
      nxt_st.pend = 1'b0;
    end
    unique case (st_ff.psel)
      PS_OFF, PS_LOW, PS_2HZ, PS_1HZ: pevent = 1'b0;
      PS_SEC: pevent = adv;
      PS_MIN: pevent = adv && tn.sec == 6'h00;
      PS_HOUR: pevent = adv && tn.sec == 6'h00 && tn.min == 6'h00;
      PS_MONTH: pevent = adv && tn.sec == 6'h00 && tn.min == 6'h00 &&
                         tn.hour == 5'h00 && tn.day == 5'h01;
    endcase
    // register writes; alarm and periodic flags clear only on written zero, halt on any control two write
    if (wr) begin
      unique case (addr)
        A_SEC: begin
          nxt_st.t.sec = wd[5:0];
          nxt_st.div = 17'h0;
          nxt_st.pend = 1'b0;
        end
        A_MIN: nxt_st.t.min = wd[5:0];
        A_HOUR: nxt_st.t.hour = wd[4:0];
        A_DAY: nxt_st.t.day = wd[4:0];
        A_MON: nxt_st.t.mon = wd[3:0];
        A_YEAR: nxt_st.t.year = wd[6:0];
        A_TRIM: nxt_st.trim = wd;
        A_AAM: nxt_st.aa_min = wd[5:0];
        A_AAH: nxt_st.aa_hour = wd[4:0];
        A_ABM: nxt_st.ab_min = wd[5:0];
        A_ABH: nxt_st.ab_hour = wd[4:0];
        A_CTL1: begin
          nxt_st.aae = wd[C1_AAE];
          nxt_st.abe = wd[C1_ABE];
          nxt_st.sel = wd[C1_SEL +: 2];
          nxt_st.psel = wd[C1_PSEL +: 3];
        end
        A_CTL2: begin
          nxt_st.halt = 1'b0;
          nxt_st.clk_en = wd[C2_CLKEN];
          if (!wd[C2_PFLAG]) begin
            nxt_st.pflag = 1'b0;
          end
          if (!wd[C2_AAF]) begin
            nxt_st.aaf = 1'b0;
          end
          if (!wd[C2_ABF]) begin
            nxt_st.abf = 1'b0;
          end
        end
        A_ADJ: begin
          if (wd[ADJ_BIT]) begin
            nxt_st.t = adj_round(nxt_st.t);
            nxt_st.pend = 1'b0;
          end
        end
        default: nxt_st.pend = nxt_st.pend;
      endcase
    end
    // hardware sets win over a clearing write in the same cycle
    if (pevent) begin
      nxt_st.pflag = 1'b1;
    end
    if (st_ff.psel == PS_2HZ || st_ff.psel == PS_1HZ) begin
      nxt_st.pflag = (st_ff.psel == PS_2HZ) ? wave2 : wave1;
    end
    if (adv && tn.sec == 6'h00 && st_ff.aae &&
        tn.min == st_ff.aa_min && tn.hour == st_ff.aa_hour) begin
      nxt_st.aaf = 1'b1;
    end
    if (adv && tn.sec == 6'h00 && st_ff.abe &&
        tn.min == st_ff.ab_min && tn.hour == st_ff.ab_hour) begin
      nxt_st.abf = 1'b1;
    end
    // pin drive
    unique case (st_ff.psel)
      PS_OFF: per_act = 1'b0;
      PS_LOW: per_act = 1'b1;
      PS_2HZ: per_act = wave2;
      PS_1HZ: per_act = wave1;
      PS_SEC, PS_MIN, PS_HOUR, PS_MONTH: per_act = st_ff.pflag;
    endcase
    a_act = (st_ff.aaf && st_ff.aae) || (st_ff.abf && st_ff.abe && !st_ff.sel[0]) ||
            (per_act && !st_ff.sel[1]);
    b_act = (st_ff.abf && st_ff.abe && st_ff.sel[0]) || (per_act && st_ff.sel[1]);
    all_act = (st_ff.aaf && st_ff.aae) || (st_ff.abf && st_ff.abe) || per_act;
    nxt_st.pin_a_n = TWO_PINS ? !a_act : 1'b1;
    nxt_st.pin_b_n = TWO_PINS ? !(b_act || (!st_ff.clk_en && !osc_level)) : 1'b1;
    nxt_st.single_n = TWO_PINS ? 1'b1 : !all_act;
    nxt_st.slow_clk = !TWO_PINS && !st_ff.clk_en && osc_level;
    nxt_st.slow_oe_n = TWO_PINS || st_ff.clk_en;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
      st_ff.t <= TIME_RST;
      st_ff.aae <= CTL1_RST[C1_AAE];
      st_ff.abe <= CTL1_RST[C1_ABE];
      st_ff.sel <= CTL1_RST[C1_SEL +: 2];
      st_ff.psel <= CTL1_RST[C1_PSEL +: 3];
      st_ff.halt <= HALT_RST;
      st_ff.clk_en <= CLKEN_RST;
      st_ff.ses <= SES_IDLE;
      st_ff.init_left <= INIT_HALVES;
      st_ff.pin_a_n <= 1'b1;
      st_ff.pin_b_n <= 1'b1;
      st_ff.single_n <= 1'b1;
      st_ff.slow_oe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_avs_waitrequest = req && !st_ff.ack;
  assign o_avs_readdata = {24'h000000, st_ff.rdata};
  assign o_pins = '{irq_a_n: st_ff.pin_a_n, irq_b_n: st_ff.pin_b_n,
                    single_n: st_ff.single_n, slow_clk: st_ff.slow_clk,
                    slow_clk_oe_n: st_ff.slow_oe_n};

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_CLKOUT_STOP: assert property (
    TWO_PINS && st_ff.clk_en && !b_act |=> o_pins.irq_b_n)
    else $error("pin B not high with clock output disabled");
  AST_SLOW_OFF: assert property (
    !TWO_PINS && st_ff.clk_en |=> !o_pins.slow_clk && o_pins.slow_clk_oe_n)
    else $error("slow clock pin still driven");
  AST_CLK_RAW: assert property (
    TWO_PINS && !st_ff.clk_en && !b_act |=> o_pins.irq_b_n == $past(osc_level))
    else $error("pin B does not follow the oscillator");
  AST_POWERUP: assert property (
    st_ff.boot == 2'h0 |-> !st_ff.clk_en && st_ff.halt)
    else $error("power-up defaults wrong");
  AST_INIT_FF: assert property (
    req && !st_ff.ack && init_busy |=> o_avs_readdata == 32'h000000ff)
    else $error("read during initialization not all ones");
  AST_HALT_KEPT: assert property (
    st_ff.boot == BOOT_DONE - 2'h1 && st_ff.strap |=> !st_ff.halt)
    else $error("halt flag set despite backup supply");
  AST_HALT_CLR: assert property (
    wr && addr == A_CTL2 |=> !st_ff.halt)
    else $error("halt flag survived control write");
  AST_TIMEOUT: assert property (
    st_ff.ses == SES_OPEN && half_tick && st_ff.ses_halves == TIMEOUT_HALVES - 2'h1
    |=> st_ff.ses == SES_IDLE)
    else $error("open access not ended by timeout");
  AST_ADJ: assert property (
    wr && addr == A_ADJ && wd[ADJ_BIT] |-> ##[1:ADJ_WIN] st_ff.t.sec == 6'h00)
    else $error("seconds not rounded in time");
  AST_PFLAG_REL: assert property (
    wr && addr == A_CTL2 && !wd[C2_PFLAG] && st_ff.psel[2] && !pevent |=> !st_ff.pflag)
    else $error("periodic flag not released");
  AST_PIN_B_HOLD: assert property (
    TWO_PINS && st_ff.abf && st_ff.abe && st_ff.sel[0] |=> !o_pins.irq_b_n)
    else $error("pin B released while alarm B pending");
  AST_OR: assert property (
    !TWO_PINS && all_act |=> !o_pins.single_n)
    else $error("single pin not low with a source active");
  AST_HELD_LOW: assert property (
    TWO_PINS && st_ff.psel == PS_LOW && !st_ff.sel[1] |=> !o_pins.irq_a_n)
    else $error("held-low mode not low on pin A");

  COV_TIMEOUT: cover property (st_ff.ses == SES_OPEN ##1 st_ff.ses == SES_IDLE);
  COV_ALARM_B: cover property ($rose(st_ff.abf));
  COV_ADJ: cover property (wr && addr == A_ADJ && wd[ADJ_BIT]);
endmodule : rco_rtc_top
`default_nettype wire

//--- bench/rco_host_model.sv
// Purpose: avalon-mm master standing in for the host processor
// Assumes: slave answers through waitrequest, one request at a time
// Notes: the bench calls xfer, the bench watchdog ends a hung wait
`timescale 1ns/1ps
`default_nettype none
module rco_host_model (
  input wire logic i_ref_clk,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata,
  output var rco_pkg::rco_avs_req_s o_avs
);
  import rco_pkg::*;

  initial o_avs = '0;

  // one whole transfer, held until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    logic w;
    @(posedge i_ref_clk);
    o_avs <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}};
    // sampled at the rising edge, before the slave's flops move
    do begin
      @(posedge i_ref_clk);
      w = i_waitrequest;
      q = i_readdata;
    end while (w !== 1'b0);
    o_avs <= '0;
  endtask : xfer
endmodule : rco_host_model
`default_nettype wire

//--- bench/tb_rco_rtc_top.sv
// Purpose: self-checking bench of the rtc clock-out block
// Assumes: shortened second of 16 oscillator edges
// Notes: a one-pin instance shares the bus with the two-pin one
`timescale 1ns/1ps
`default_nettype none
module tb_rco_rtc_top;
  import rco_pkg::*;
  localparam int unsigned OPS = 16;
  logic clk;
  logic rst_n;
  logic osc;
  logic backup;
  rco_avs_req_s avs;
  logic wait1;
  logic wait2;
  logic [31:0] rd1;
  logic [31:0] rd2;
  rco_pins_s pins;
  rco_pins_s pins2;
  int errors;
  int checks;
  int n;
  logic [2:0] modes [4];

  rco_rtc_top #(.OSC_PER_SEC(OPS), .TWO_PINS(1'b1)) dut (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_osc_clk(osc), .i_backup_kept(backup), .i_avs(avs), .o_avs_waitrequest(wait1),
    .o_avs_readdata(rd1), .o_pins(pins));
  rco_rtc_top #(.OSC_PER_SEC(OPS), .TWO_PINS(1'b0)) dut_one_pin (.i_ref_clk(clk),
    .i_rst_n(rst_n), .i_osc_clk(osc), .i_backup_kept(backup), .i_avs(avs),
    .o_avs_waitrequest(wait2), .o_avs_readdata(rd2), .o_pins(pins2));
  rco_host_model host (.i_ref_clk(clk), .i_waitrequest(wait1), .i_readdata(rd1),
    .o_avs(avs));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // crystal runs free, phase unrelated to the reference clock
  initial begin
    osc = 1'b0;
    #7;
    forever #160 osc = ~osc;
  end

  task automatic close_out();
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic rng(input int v, input int lo, input int hi);
    checks++;
    if (v < lo || v > hi) begin
      errors++;
      $display("mismatch %0t got %h exp %h..%h", $time, v, lo, hi);
    end
  endtask : rng

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
    chk(rd2, e);
  endtask : rd

  task automatic gap(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask : gap

  // edges seen on pin b over c cycles
  task automatic toggles(input int c, output int t);
    logic p;
    t = 0;
    @(negedge clk);
    p = pins.irq_b_n;
    repeat (c) begin
      @(negedge clk);
      if (pins.irq_b_n !== p) t++;
      p = pins.irq_b_n;
    end
  endtask : toggles

  task automatic do_reset(input logic b);
    @(posedge clk);
    rst_n <= 1'b0;
    backup <= b;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  // poll the busy bit until initialization is over
  task automatic wait_init();
    logic [31:0] q;
    repeat (100) begin
      host.xfer(1'b0, A_SES, 8'h00, q);
      if (q[1] === 1'b0) break;
    end
  endtask : wait_init

  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    close_out();
  end

  initial begin
    errors = 0;
    checks = 0;
    rst_n = 1'b0;
    backup = 1'b0;
    modes = '{PS_OFF, PS_MIN, PS_HOUR, PS_MONTH};
    do_reset(1'b0);
    rd(A_CTL2, 32'hff);
    chk(pins.irq_a_n, 1'b1);
    chk(pins2.slow_clk_oe_n, 1'b0);
    chk({pins.single_n, pins.slow_clk, pins2.irq_a_n, pins2.irq_b_n}, 4'hb);
    toggles(80, n);
    rng(n, 19, 21);
    wait_init();
    rd(A_CTL2, 32'h10);
    rd(6'h3c, 32'h00);
    wr(A_TRIM, 8'h05);
    toggles(160, n);
    rng(n, 39, 41);
    wr(A_TRIM, 8'h00);
    wr(A_CTL2, 8'h08);
    rd(A_CTL2, 32'h08);
    toggles(80, n);
    rng(n, 0, 0);
    chk(pins.irq_b_n, 1'b1);
    chk({pins2.slow_clk, pins2.slow_clk_oe_n}, 2'h1);
    wr(A_CTL1, {5'h04, PS_LOW});
    gap(3);
    chk(pins.irq_b_n, 1'b0);
    chk(pins2.single_n, 1'b0);
    wr(A_CTL1, {5'h00, PS_LOW});
    gap(3);
    chk({pins.irq_a_n, pins.irq_b_n}, 2'h1);
    // restart the second so the next tick lands between the two pin b checks
    wr(A_SEC, 8'h00);
    wr(A_SES, 8'h00);
    wr(A_CTL1, {5'h04, PS_SEC});
    wr(A_CTL2, 8'h08);
    gap(2);
    chk(pins.irq_b_n, 1'b1);
    gap(140);
    chk(pins.irq_b_n, 1'b0);
    rd(A_CTL2, 32'h0c);
    wr(A_CTL2, 8'h08);
    gap(2);
    chk(pins.irq_b_n, 1'b1);
    wr(A_CTL1, {5'h04, PS_2HZ});
    toggles(512, n);
    rng(n, 15, 17);
    wr(A_CTL1, {5'h04, PS_1HZ});
    toggles(512, n);
    rng(n, 7, 9);
    foreach (modes[i]) begin
      wr(A_CTL1, {5'h04, modes[i]});
      wr(A_CTL2, 8'h08);
      gap(3);
      chk(pins.irq_b_n, 1'b1);
    end
    wr(A_MIN, 8'h05);
    wr(A_SEC, 8'h28);
    wr(A_SES, 8'h00);
    wr(A_ADJ, 8'h01);
    rd(A_SEC, 32'h00);
    rd(A_MIN, 32'h06);
    rd(A_SES, 32'h01);
    gap(60);
    rd(A_SES, 32'h01);
    gap(200);
    rd(A_SES, 32'h00);
    // time set and read back as one open access each
    wr(A_SEC, 8'h3b);
    wr(A_MIN, 8'h09);
    wr(A_HOUR, 8'h03);
    wr(A_DAY, 8'h0f);
    wr(A_MON, 8'h06);
    wr(A_YEAR, 8'h19);
    wr(A_SES, 8'h00);
    rd(A_SEC, 32'h3b);
    rd(A_MIN, 32'h09);
    rd(A_HOUR, 32'h03);
    rd(A_DAY, 32'h0f);
    rd(A_MON, 32'h06);
    rd(A_YEAR, 32'h19);
    wr(A_SES, 8'h00);
    // alarm b loaded while disabled, routed to pin b
    wr(A_CTL1, 8'h10);
    wr(A_ABM, 8'h0a);
    wr(A_ABH, 8'h03);
    wr(A_CTL1, 8'h50);
    gap(2);
    chk(pins.irq_b_n, 1'b1);
    gap(100);
    chk(pins.irq_b_n, 1'b0);
    rd(A_CTL2, 32'h09);
    wr(A_CTL2, 8'h0e);
    gap(2);
    chk(pins.irq_b_n, 1'b1);
    do_reset(1'b1);
    wait_init();
    rd(A_CTL2, 32'h00);
    wr(A_CTL1, {5'h04, PS_LOW});
    gap(2);
    chk(pins.irq_b_n, 1'b0);
    close_out();
  end
endmodule : tb_rco_rtc_top
`default_nettype wire
